// file: hdl/sad_cfg.svh
`ifndef SAD_CFG_SVH
`define SAD_CFG_SVH

// =====================================================================
// adder geometry
`define SAD_W 12
`define SAD_GW 3
`define SAD_GROUPS 4
`define SAD_GROUP_IDX_W 2

// =====================================================================
// operand constants, as true values before the inverters
`define SAD_ZERO 12'h000
`define SAD_ONE 12'h001
// inverter input for a plus-one request: ones everywhere but stage 0
`define SAD_PLUS_ONE_INV 12'hffe

// =====================================================================
// reset values
`define SAD_RESULT_RST 12'h000
`define SAD_INV_RST 12'hfff

`endif

// file: hdl/sad_pkg.sv
package sad_pkg;

  // ===================================================================
  // sequencer states: idle, then clear, toggle, probe in that order
  typedef enum logic [1:0] {
    st_idle,
    st_clear,
    st_toggle,
    st_probe
  } sad_state_e;

  // ===================================================================
  // adder-control commands
  typedef enum logic [3:0] {
    cmd_a_plus_one,
    cmd_a_plus_z,
    cmd_a_minus_z,
    cmd_z_plus_one,
    cmd_log_product,
    cmd_sel_compl,
    cmd_replace_add_one,
    cmd_xfer_a,
    cmd_xfer_neg_z,
    cmd_xfer_z,
    cmd_shl
  } sad_cmd_e;

  // ===================================================================
  // the two operand registers feeding the input selects
  typedef struct packed {
    logic [11:0] a;
    logic [11:0] z;
  } sad_oper_s;

  // ===================================================================
  // whole state of the adder
  typedef struct packed {
    sad_state_e fsm;
    sad_cmd_e cmd;
    sad_oper_s oper;
    logic [11:0] r_inv;
    logic [11:0] q_inv;
    logic [11:0] result;
    logic busy;
    logic done;
  } sad_state_s;

endpackage

// file: hdl/sad_group.sv
`timescale 1ns/10ps

// =====================================================================
// one octal group of three adder stages
module sad_group (
  input wire logic [2:0] r_op_in,
  input wire logic [2:0] q_op_in,
  input wire logic gbi_in,
  output logic group_borrow_n_out,
  output logic group_enable_n_out,
  output logic [2:0] stage_en_out,
  output logic [2:0] probe_out
);

  logic [2:0] stage_borrow;
  logic [2:0] borrow_in;
  logic carry;

  // stage signals: borrow on both zero, enable on unlike bits
  assign stage_borrow = ~r_op_in & ~q_op_in;
  assign stage_en_out = r_op_in ^ q_op_in;

  // group outputs are active low, as the inverter logic gives them
  assign group_borrow_n_out = ~(stage_borrow[2]
    | (stage_en_out[2] & stage_borrow[1])
    | (stage_en_out[2] & stage_en_out[1] & stage_borrow[0]));
  assign group_enable_n_out = ~(&stage_en_out);

  // borrow acting on each stage: from below, or passed through enables
  always_comb begin
    carry = gbi_in;
    for (int i = 0; i < 3; i++) begin
      borrow_in[i] = carry;
      carry = stage_borrow[i] | (stage_en_out[i] & carry);
    end
  end

  // probe input drops to zero wherever a borrow acts
  assign probe_out = ~borrow_in;

endmodule // sad_group

// file: hdl/sad_adder.sv
`timescale 1ns/10ps
`include "sad_cfg.svh"

// =====================================================================
module sad_adder (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic start_in,
  input wire sad_pkg::sad_cmd_e cmd_in,
  input wire sad_pkg::sad_oper_s oper_in,
  input wire logic cycle_d_phase_three_in,
  output logic [`SAD_W-1:0] result_out,
  output logic busy_out,
  output logic done_out
);

  // ===================================================================
  // declarations
  sad_pkg::sad_state_s st_reg;
  sad_pkg::sad_state_s st_next;
  logic [`SAD_W-1:0] r_val;
  logic [`SAD_W-1:0] q_val;
  logic [`SAD_W-1:0] r_op;
  logic [`SAD_W-1:0] q_op;
  logic [`SAD_W-1:0] stage_en;
  logic [`SAD_W-1:0] spi;
  logic [`SAD_GROUPS-1:0] gb_n;
  logic [`SAD_GROUPS-1:0] ge_n;
  logic gbi_c [`SAD_GROUPS];
  logic shift_hold;
  logic [`SAD_W:0] diff_c;
  logic [`SAD_W-1:0] expect_c;

  // ===================================================================
  // input selects: true operand values per command
  // a zero operand means the inverter is fed all ones
  always_comb begin
    r_val = `SAD_ZERO;
    q_val = `SAD_ZERO;
    unique case (st_reg.cmd)
      sad_pkg::cmd_a_plus_one: begin
        r_val = `SAD_ONE;
        q_val = st_reg.oper.a;
      end
      sad_pkg::cmd_a_plus_z: begin
        r_val = st_reg.oper.z;
        q_val = st_reg.oper.a;
      end
      sad_pkg::cmd_a_minus_z: begin
        r_val = ~st_reg.oper.z;
        q_val = st_reg.oper.a;
      end
      sad_pkg::cmd_z_plus_one: begin
        r_val = st_reg.oper.z;
        q_val = `SAD_ONE;
      end
      sad_pkg::cmd_log_product: begin
        q_val = st_reg.oper.z & st_reg.oper.a;
      end
      sad_pkg::cmd_sel_compl: begin
        q_val = st_reg.oper.z ^ st_reg.oper.a;
      end
      sad_pkg::cmd_replace_add_one: begin
        r_val = `SAD_ONE;
        q_val = st_reg.oper.a;
      end
      sad_pkg::cmd_xfer_a: begin
        q_val = st_reg.oper.a;
      end
      sad_pkg::cmd_xfer_neg_z: begin
        r_val = ~st_reg.oper.z;
      end
      sad_pkg::cmd_xfer_z: begin
        r_val = st_reg.oper.z;
      end
      sad_pkg::cmd_shl: begin
        // ones'-complement doubling: the top bit comes round
        q_val = {st_reg.oper.a[`SAD_W-2:0], st_reg.oper.a[`SAD_W-1]};
      end
      default: begin
        r_val = `SAD_ZERO;
        q_val = `SAD_ZERO;
      end
    endcase
  end

  // ===================================================================
  // inverter outputs give the operands seen by the stages
  assign r_op = ~st_reg.r_inv;
  assign q_op = ~st_reg.q_inv;

  // a shift waits in clear until phase three of cycle d
  assign shift_hold = (st_reg.cmd == sad_pkg::cmd_shl)
    && !cycle_d_phase_three_in;

  // ===================================================================
  // octal groups and their group borrow input circuits
  for (genvar g = 0; g < `SAD_GROUPS; g++) begin : g_grp
    sad_group u_grp (
      .r_op_in(r_op[`SAD_GW*g +: `SAD_GW]),
      .q_op_in(q_op[`SAD_GW*g +: `SAD_GW]),
      .gbi_in(gbi_c[g]),
      .group_borrow_n_out(gb_n[g]),
      .group_enable_n_out(ge_n[g]),
      .stage_en_out(stage_en[`SAD_GW*g +: `SAD_GW]),
      .probe_out(spi[`SAD_GW*g +: `SAD_GW])
    );

    // walk down from the adjacent group round to this one; the last
    // step is the end-around borrow from the group itself. reading
    // only group outputs keeps the ring free of a combinational loop.
    always_comb begin
      int idx;
      logic hold_n;
      logic group_borrow_input;
      idx = 0;
      hold_n = 1'b0;
      group_borrow_input = 1'b0;
      for (int k = 1; k <= `SAD_GROUPS; k++) begin
        idx = (g + `SAD_GROUPS - k) % `SAD_GROUPS;
        group_borrow_input = group_borrow_input | ~(gb_n[idx] | hold_n);
        hold_n = hold_n | ge_n[idx];
      end
      gbi_c[g] = group_borrow_input;
    end
  end

  // ===================================================================
  // sequencer and result register
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    unique case (st_reg.fsm)
      sad_pkg::st_idle: begin
        // requests during a busy operation are simply not looked at
        if (start_in) begin
          st_next.fsm = sad_pkg::st_clear;
          st_next.cmd = cmd_in;
          st_next.oper = oper_in;
          st_next.busy = 1'b1;
        end
      end
      sad_pkg::st_clear: begin
        st_next.result = `SAD_RESULT_RST;
        if (!shift_hold) begin
          st_next.r_inv = ~r_val;
          st_next.q_inv = ~q_val;
          st_next.fsm = sad_pkg::st_toggle;
        end
      end
      sad_pkg::st_toggle: begin
        st_next.result = st_reg.result | stage_en;
        st_next.fsm = sad_pkg::st_probe;
      end
      sad_pkg::st_probe: begin
        st_next.result = st_reg.result ^ spi;
        st_next.fsm = sad_pkg::st_idle;
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
      end
    endcase
  end

  // one register for all state; the enums reset to their first member
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st_reg <= sad_pkg::sad_state_s'(0);
      st_reg.r_inv <= `SAD_INV_RST;
      st_reg.q_inv <= `SAD_INV_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign result_out = st_reg.result;
  assign busy_out = st_reg.busy;
  assign done_out = st_reg.done;

  // ===================================================================
  // reference for checks: minuend r minus complement of q,
  // with an end-around borrow taken off the low end
  assign diff_c = {1'b0, r_op} - {1'b0, ~q_op};
  assign expect_c = diff_c[`SAD_W] ? (diff_c[`SAD_W-1:0] - `SAD_ONE)
                                   : diff_c[`SAD_W-1:0];

  // ===================================================================
  // checks
  a_start_taken: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_idle && start_in)
      |=> (st_reg.fsm == sad_pkg::st_clear && busy_out))
    else $error("start not taken into clear");

  a_clear_zero: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_clear) |=> (result_out == `SAD_ZERO))
    else $error("clear left a stage set");

  a_toggle_sets: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_toggle) |=> (result_out == $past(stage_en)))
    else $error("toggle result is not the enable pattern");

  a_probe_keeps: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_probe && !spi[0])
      |=> (result_out[0] == $past(result_out[0])))
    else $error("borrowed stage changed in probe");

  a_sum_right: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_probe) |=> (result_out == $past(expect_c)))
    else $error("probe result differs from subtractive sum");

  a_borrow_next: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    !gb_n[0] |-> gbi_c[1])
    else $error("group borrow not seen by next group");

  a_borrow_wrap: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (!gb_n[3] && !ge_n[1] && !ge_n[0]) |-> (gbi_c[0] && gbi_c[1]
      && gbi_c[2]))
    else $error("end-around borrow not passed on");

  a_no_borrow: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (&gb_n) |-> !gbi_c[2])
    else $error("borrow input with no group borrowing");

  a_enable_low: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (ge_n[1] == !(&stage_en[5:3])))
    else $error("group enable polarity wrong");

  a_plus_one_inv: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_clear
      && st_reg.cmd == sad_pkg::cmd_a_plus_one)
      |=> (st_reg.r_inv == `SAD_PLUS_ONE_INV))
    else $error("plus-one inverter input wrong");

  a_shift_phase: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_clear && st_reg.cmd == sad_pkg::cmd_shl
      && !cycle_d_phase_three_in) |=> (st_reg.fsm == sad_pkg::st_clear))
    else $error("shift left clear outside phase three");

  a_shift_value: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_clear && st_reg.cmd == sad_pkg::cmd_shl
      && cycle_d_phase_three_in) |=> (q_op == {$past(st_reg.oper.a[10:0]),
      $past(st_reg.oper.a[11])}) && (r_op == `SAD_ZERO))
    else $error("shift operand is not a times two");

  a_step_order: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_toggle) |=> (st_reg.fsm == sad_pkg::st_probe)
      ##1 (st_reg.fsm == sad_pkg::st_idle && done_out && !busy_out))
    else $error("toggle and probe out of order");

  a_done_hold: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (done_out && !start_in) |=> (result_out == $past(result_out)))
    else $error("result moved after completion");

  // busy must mirror any step away from idle, or a start slips in
  a_busy_span: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    ((st_reg.fsm != sad_pkg::st_idle) == busy_out))
    else $error("busy does not match the step sequence");

  // done is a single-cycle strobe even with back-to-back starts
  a_done_pulse: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    done_out |=> !done_out)
    else $error("done held for more than one cycle");

  // the operands loaded in clear must not move under toggle and probe
  a_inv_steady: assert property (
    @(posedge ref_clk_in) disable iff (srst_in)
    (st_reg.fsm == sad_pkg::st_toggle)
      |=> ($stable(st_reg.r_inv) && $stable(st_reg.q_inv)))
    else $error("inverter inputs changed after clear");

endmodule // sad_adder

// file: verification/sad_adder_tb.sv
`timescale 1ns/10ps
`include "sad_cfg.svh"

module testbench;
  // =====================================================================
  // stimulus and observation signals
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic start_in = 1'b0;
  logic phase_three = 1'b0;
  sad_pkg::sad_cmd_e cmd_in = sad_pkg::cmd_xfer_a;
  sad_pkg::sad_oper_s oper_in = '0;
  logic [11:0] result_out;
  logic busy_out;
  logic done_out;
  int err_total = 0;
  int cmp_count = 0;
  logic [11:0] exp_q[$];
  logic done_d = 1'b0;

  sad_adder dut_u (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .start_in(start_in),
    .cmd_in(cmd_in),
    .oper_in(oper_in),
    .cycle_d_phase_three_in(phase_three),
    .result_out(result_out),
    .busy_out(busy_out),
    .done_out(done_out)
  ); // sad_adder

  // =====================================================================
  // 10 mhz clock
  initial begin
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // =====================================================================
  // shared helpers
  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  function automatic logic [11:0] rnd12();
    logic [31:0] rv;
    rv = $urandom();
    return rv[11:0];
  endfunction

  // true operand values ahead of the inverters, per command
  function automatic void operands(input sad_pkg::sad_cmd_e c,
      input logic [11:0] a, input logic [11:0] z,
      output logic [11:0] r, output logic [11:0] q);
    r = 12'h000;
    q = a;
    case (c)
      sad_pkg::cmd_a_plus_one, sad_pkg::cmd_replace_add_one: r = 12'h001;
      sad_pkg::cmd_a_plus_z: r = z;
      sad_pkg::cmd_a_minus_z: r = ~z;
      sad_pkg::cmd_z_plus_one: begin
        r = z;
        q = 12'h001;
      end
      sad_pkg::cmd_log_product: q = z & a;
      sad_pkg::cmd_sel_compl: q = z ^ a;
      sad_pkg::cmd_xfer_neg_z: begin
        r = ~z;
        q = 12'h000;
      end
      sad_pkg::cmd_xfer_z: begin
        r = z;
        q = 12'h000;
      end
      sad_pkg::cmd_shl: q = {a[10:0], a[11]};
      default: ;
    endcase
  endfunction

  // subtract the complement, end-around borrow takes one more off
  function automatic logic [11:0] sub_add(input logic [11:0] r,
                                          input logic [11:0] q);
    logic [11:0] nq;
    nq = ~q;
    return (r >= nq) ? r - nq : r - nq - 12'h001;
  endfunction

  // =====================================================================
  // one operation; next start goes out in the done cycle (back to back)
  task automatic run_op(input sad_pkg::sad_cmd_e c, input logic [11:0] a,
      input logic [11:0] z, input int d3_wait, input bit poke);
    logic [11:0] r;
    logic [11:0] q;
    bit seen0;
    bit seen_t;
    int n;
    operands(c, a, z, r, q);
    exp_q.push_back(sub_add(r, q));
    start_in = 1'b1;
    cmd_in = c;
    oper_in = '{a: a, z: z};
    @(posedge ref_clk_in) #1;
    start_in = 1'b0;
    seen0 = 1'b0;
    seen_t = 1'b0;
    // a shift must park in clear until phase three arrives
    for (n = 0; n < d3_wait; n++) begin
      @(posedge ref_clk_in) #1;
      if (n > 0) begin
        chk("shift_wait_busy", 12'h001, {11'h000, busy_out});
        chk("shift_wait_result", 12'h000, result_out);
      end
    end
    phase_three = (c == sad_pkg::cmd_shl);
    for (n = 0; n < 12; n++) begin
      // a start while busy must be ignored, operands changed too
      if (poke && n == 1) begin
        start_in = 1'b1;
        oper_in = ~oper_in;
      end
      if (poke && n == 2) begin
        start_in = 1'b0;
      end
      @(posedge ref_clk_in) #1;
      seen0 |= (result_out === 12'h000 && busy_out === 1'b1);
      seen_t |= (result_out === (r ^ q));
      if (done_out === 1'b1) begin
        break;
      end
    end
    if (done_out !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED done expected 1 seen 0");
      close_out();
    end
    chk("clear_seen", 12'h001, {11'h000, seen0});
    chk("toggle_seen", 12'h001, {11'h000, seen_t});
    chk("busy_at_done", 12'h000, {11'h000, busy_out});
    phase_three = 1'b0;
  endtask

  // =====================================================================
  // result watcher: every done pulse retires the oldest note
  always @(posedge ref_clk_in) begin
    #5;
    if (done_out === 1'b1) begin
      if (done_d) begin
        err_total++;
        $display("CHECK FAILED done_width expected 0 seen 1");
      end
      if (exp_q.size() == 0) begin
        err_total++;
        $display("CHECK FAILED done_count expected 0 seen 1");
      end else begin
        chk("result", exp_q.pop_front(), result_out);
      end
    end
    done_d = (done_out === 1'b1);
  end

  // =====================================================================
  // main sequence
  initial begin
    int i;
    logic [31:0] seed_rv;
    seed_rv = $urandom(69);
    repeat (2) @(posedge ref_clk_in);
    #1;
    srst_in = 1'b0;
    chk("reset_result", `SAD_RESULT_RST, result_out);
    chk("reset_flags", 12'h000, {10'h000, busy_out, done_out});
    $display("test reset done");
    // worked examples plus end-around and zero corners
    run_op(sad_pkg::cmd_a_plus_z, 12'h00c, 12'h02d, 0, 1'b0);
    run_op(sad_pkg::cmd_a_plus_z, 12'h02b, 12'h055, 0, 1'b0);
    run_op(sad_pkg::cmd_a_plus_z, 12'h000, 12'h000, 0, 1'b0);
    run_op(sad_pkg::cmd_a_plus_z, 12'hfff, 12'h000, 0, 1'b0);
    run_op(sad_pkg::cmd_a_plus_z, 12'h800, 12'h800, 0, 1'b0);
    run_op(sad_pkg::cmd_a_minus_z, 12'h005, 12'h005, 0, 1'b0);
    run_op(sad_pkg::cmd_a_plus_z, 12'hfff, 12'h001, 0, 1'b0);
    $display("test directed done");
    // every command, random operands, twice
    for (i = 0; i < 22; i++) begin
      run_op(sad_pkg::sad_cmd_e'(i % 11), rnd12(), rnd12(),
             (i == 10) ? 4 : 0, i == 2);
    end
    $display("test commands done");
    // reset landing in mid operation
    start_in = 1'b1;
    cmd_in = sad_pkg::cmd_a_plus_z;
    oper_in = '{a: rnd12(), z: rnd12()};
    @(posedge ref_clk_in) #1;
    start_in = 1'b0;
    @(posedge ref_clk_in) #1;
    srst_in = 1'b1;
    repeat (2) @(posedge ref_clk_in);
    #1;
    srst_in = 1'b0;
    chk("mid_reset_result", 12'h000, result_out);
    chk("mid_reset_flags", 12'h000, {10'h000, busy_out, done_out});
    run_op(sad_pkg::cmd_shl, 12'h801, 12'h000, 0, 1'b0);
    $display("test mid reset done");
    repeat (3) @(posedge ref_clk_in);
    close_out();
  end
endmodule // testbench
